/* File: hdl/sar_adc_control.v */
// apb register file and successive-approximation sequencer
`timescale 1ns/1ns
`include "sar_adc_defines.vh"
// register map, one byte per word, upper bits read zero
//   control main at 0x000: clock low bits, channel, busy, power
//   config format at 0x004: justify, clock high bit, pin map code
//   result high at 0x008, follows the current justification
//   result low at 0x00C, follows the current justification
//   interrupt control at 0x010: done flag, irq enable
//   any other address answers with slave error and zero data
//
// bus timing
//   ready rises in the access cycle of every transfer
//   read data is captured in the setup cycle
//   writes land at the end of the access cycle
//   no wait states are ever inserted
//
// conversion sequence
//   software powers the converter in one write
//   a later write with busy set starts the conversion
//   a start together with power-on is ignored
//   twelve bit periods follow, periods 1..10 decide bits
//   the last period loads the result and sets the flag
//   two bit periods of settling follow before idle
//   clearing busy or power mid-way aborts the conversion
//   an abort leaves the result pair untouched unless it falls on the completing tick
//
// clocking
//   bit periods come from the divider as one-cycle ticks
//   oscillator divides by 2 to 64, rc by RC_DIV cycles
//   in sleep only the rc source keeps ticking
//   a divided source in sleep stalls the sequencer
//
// hazards
//   the result pair has no reset, reads unknown after power-on
//   channel changes mid-conversion do not touch the held sample
//   hardware setting the flag wins over a software clear
//   the comparator is sampled one bit period after each new trial code, two cycles at osc/2
//

module sar_adc_control #(
    parameter RC_DIV = 100                  // system cycles per rc bit period
) (
    input  wire        sys_clk_in,          // system clock 25 mhz
    input  wire        rst_n_in,            // synchronous reset, active low
    input  wire        psel_in,             // apb select
    input  wire        penable_in,          // apb enable
    input  wire        pwrite_in,           // apb write
    input  wire [11:0] paddr_in,            // apb byte address
    input  wire [31:0] pwdata_in,           // apb write data
    output reg  [31:0] prdata_out,          // apb read data
    output reg         pready_out,          // apb ready
    output reg         pslverr_out,         // apb error, unmapped address
    input  wire        sleep_in,            // device is in sleep
    input  wire        comp_in,             // comparator: sample above dac
    output reg  [2:0]  channel_out,         // mux channel to sample/hold
    output reg         hold_out,            // high: hold cap disconnected
    output reg  [9:0]  dac_code_out,        // trial code to comparator dac
    output reg         power_out,           // analog power enable
    output reg  [7:0]  pin_analog_out,      // per pin, high means analog
    output reg         vref_pos_ext_out,    // high ref from input 3
    output reg         vref_neg_ext_out,    // low ref from input 2
    output reg         irq_out              // conversion interrupt request
);
    // state codes
    localparam ST_IDLE = 2'h0;              // acquiring or off
    localparam ST_CONV = 2'h1;              // converting
    localparam ST_WAIT = 2'h2;              // post-conversion wait

    reg  [7:0]  main_q;                     // control main register
    reg  [7:0]  cfg_q;                      // config format register
    reg  [9:0]  result_q;                   // ten-bit result, not reset
    reg         flag_q;                     // done flag
    reg         irq_en_q;                   // interrupt enable
    reg  [1:0]  state_q;                    // sequencer state
    reg  [3:0]  tad_cnt_q;                  // bit period counter
    reg  [9:0]  sar_q;                      // approximation register
    reg  [3:0]  bit_q;                      // bit under trial
    wire        tad_tick;                   // bit period enable
    wire [2:0]  clk_sel;                    // combined clock selection
    wire        bus_acc;                    // apb access phase
    wire        bus_wr;                     // apb write strobe
    wire        wr_main;                    // write main control
    wire        conv_done;                  // completion point
    wire        sw_abort;                   // software cleared busy
    wire        clock_ok;                   // clock usable now
    reg  [7:0]  map_w;                      // decoded pin map
    reg  [15:0] res_w;                      // justified result pair

    assign clk_sel  = {cfg_q[`CF_CLKHI_BIT], main_q[`CM_CLKLO_LSB+1:`CM_CLKLO_LSB]};
    assign bus_acc  = psel_in & penable_in;
    assign bus_wr   = bus_acc & pwrite_in;
    assign wr_main  = bus_wr && (paddr_in == `OFS_CONTROL_MAIN);
    // in sleep only the rc source keeps running
    assign clock_ok = !sleep_in || (clk_sel[1:0] == 2'h3);
    assign conv_done = (state_q == ST_CONV) && tad_tick
                       && (tad_cnt_q == `CONV_PERIODS - 4'h1);
    assign sw_abort = wr_main && !pwdata_in[`CM_BUSY_BIT] && (state_q == ST_CONV);

    // conversion clock divider
    sar_adc_tad_divider #(
        .RC_DIV       (RC_DIV)
    ) u_div (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .run_in       (main_q[`CM_POWER_BIT] && clock_ok && state_q != ST_IDLE),
        .clk_sel_in   (clk_sel),
        .tad_tick_out (tad_tick)
    );

    // pin map decode per configuration code
    // bit n high marks pin n as analog input
    // reference pins count as non-analog in the map
    // codes 6 and 7 both turn every pin digital
    // codes 14 and 15 keep only input 0 analog
    always @* begin
        case (cfg_q[3:0])
            4'h0:    map_w = 8'hFF;         // all analog
            4'h1:    map_w = 8'hF7;
            4'h2:    map_w = 8'h1F;
            4'h3:    map_w = 8'h17;
            4'h4:    map_w = 8'h0B;
            4'h5:    map_w = 8'h03;
            4'h6:    map_w = 8'h00;         // all digital
            4'h7:    map_w = 8'h00;         // all digital
            4'h8:    map_w = 8'hF3;
            4'h9:    map_w = 8'h3F;
            4'hA:    map_w = 8'h37;
            4'hB:    map_w = 8'h33;
            4'hC:    map_w = 8'h13;
            4'hD:    map_w = 8'h03;
            4'hE:    map_w = 8'h01;
            default: map_w = 8'h01;
        endcase
    end

    // justified result pair, unused bits zero
    always @* begin
        if (cfg_q[`CF_JUSTIFY_BIT])
            res_w = {6'h00, result_q};      // right justified
        else
            res_w = {result_q, 6'h00};      // left justified
    end

    // control registers, flag and sequencer
    // idle: busy held low, start accepted only with power already on
    // conv: one bit decided per tick in periods 1..10, msb first, twelve ticks total
    // wait: two ticks of settling before the next start is taken
    // an abort enters wait straight away, the result untouched unless completion lands in the same cycle
    // power-off in wait drops back to idle at once
    // the tick counter restarts on every entry to conv or wait
    // trial code starts at mid scale, each decision sets the next bit
    // comparator low clears the bit under trial
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            main_q    <= `RST_CONTROL_MAIN;
            cfg_q     <= `RST_CONFIG_FORMAT;
            flag_q    <= 1'b0;
            irq_en_q  <= 1'b0;
            state_q   <= ST_IDLE;           // abort any conversion
            tad_cnt_q <= 4'h0;
            sar_q     <= 10'h000;
            bit_q     <= 4'h9;
        end else begin
            // software writes, bit 1 never stored
            if (wr_main) begin
                main_q[7:3] <= pwdata_in[7:3];
                main_q[`CM_POWER_BIT] <= pwdata_in[`CM_POWER_BIT];
            end
            if (bus_wr && paddr_in == `OFS_CONFIG_FORMAT)
                cfg_q <= {pwdata_in[7:6], 2'h0, pwdata_in[3:0]};
            if (bus_wr && paddr_in == `OFS_IRQ_CTRL)
                irq_en_q <= pwdata_in[`IC_ENABLE_BIT];
            // flag: hardware set wins over software clear
            if (conv_done)
                flag_q <= 1'b1;
            else if (bus_wr && paddr_in == `OFS_IRQ_CTRL)
                flag_q <= pwdata_in[`IC_FLAG_BIT];
            // sequencer
            case (state_q)
                ST_IDLE: begin
                    main_q[`CM_BUSY_BIT] <= 1'b0;
                    if (wr_main && pwdata_in[`CM_BUSY_BIT] && main_q[`CM_POWER_BIT]
                        && pwdata_in[`CM_POWER_BIT]) begin
                        main_q[`CM_BUSY_BIT] <= 1'b1;
                        state_q   <= ST_CONV;
                        tad_cnt_q <= 4'h0;
                        sar_q     <= 10'h200;
                        bit_q     <= 4'h9;
                    end
                end
                ST_CONV: begin
                    if (sw_abort || (wr_main && !pwdata_in[`CM_POWER_BIT])) begin
                        main_q[`CM_BUSY_BIT] <= 1'b0;
                        state_q   <= ST_WAIT;
                        tad_cnt_q <= 4'h0;
                    end else if (tad_tick) begin
                        tad_cnt_q <= tad_cnt_q + 4'h1;
                        // periods 1..10 decide one bit each, msb first
                        if (tad_cnt_q >= 4'h1 && tad_cnt_q <= 4'hA) begin
                            if (!comp_in)
                                sar_q[bit_q] <= 1'b0;
                            if (bit_q != 4'h0)
                                sar_q[bit_q - 4'h1] <= 1'b1;
                            bit_q <= bit_q - 4'h1;
                        end
                        if (conv_done) begin
                            main_q[`CM_BUSY_BIT] <= 1'b0;
                            state_q   <= ST_WAIT;
                            tad_cnt_q <= 4'h0;
                        end
                    end
                end
                ST_WAIT: begin
                    main_q[`CM_BUSY_BIT] <= 1'b0;
                    if (!main_q[`CM_POWER_BIT])
                        state_q <= ST_IDLE;
                    else if (tad_tick) begin
                        tad_cnt_q <= tad_cnt_q + 4'h1;
                        if (tad_cnt_q == `WAIT_PERIODS - 4'h1)
                            state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // result pair: loaded on completion or by software, no reset
    // completion wins over a software write in the same cycle
    // software writes place bits by the current justification
    // reset is only a gate here, never a value
    always @(posedge sys_clk_in) begin
        if (rst_n_in && conv_done)
            result_q <= sar_q;
        else if (rst_n_in && bus_wr && paddr_in == `OFS_RESULT_HIGH)
            result_q <= cfg_q[`CF_JUSTIFY_BIT] ? {pwdata_in[1:0], result_q[7:0]}
                                               : {pwdata_in[7:0], result_q[1:0]};
        else if (rst_n_in && bus_wr && paddr_in == `OFS_RESULT_LOW)
            result_q <= cfg_q[`CF_JUSTIFY_BIT] ? {result_q[9:8], pwdata_in[7:0]}
                                               : {result_q[9:2], pwdata_in[7:6]};
    end

    // apb answer, one access cycle, registered read data
    // setup cycle decodes the address and captures read data
    // ready and error stand for the access cycle only
    // unused upper bits of every register read as zero
    // unmapped reads return zero with the error flag
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            prdata_out  <= 32'h0000_0000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= psel_in && !penable_in;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            if (psel_in && !penable_in) begin
                case (paddr_in)
                    `OFS_CONTROL_MAIN:  prdata_out <= {24'h0, main_q & 8'hFD};
                    `OFS_CONFIG_FORMAT: prdata_out <= {24'h0, cfg_q & 8'hCF};
                    `OFS_RESULT_HIGH:   prdata_out <= {24'h0, res_w[15:8]};
                    `OFS_RESULT_LOW:    prdata_out <= {24'h0, res_w[7:0]};
                    `OFS_IRQ_CTRL:      prdata_out <= {30'h0, irq_en_q, flag_q};
                    default:            pslverr_out <= 1'b1;
                endcase
            end
        end
    end

    // analog side outputs, all registered
    // every output but irq_out lags its register by one clock
    // reset drives every shared pin to analog input
    // hold stays high for the whole conversion
    // interrupt request follows flag and enable
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            channel_out      <= 3'h0;
            hold_out         <= 1'b0;
            dac_code_out     <= 10'h000;
            power_out        <= 1'b0;
            pin_analog_out   <= 8'hFF;
            vref_pos_ext_out <= 1'b0;
            vref_neg_ext_out <= 1'b0;
            irq_out          <= 1'b0;
        end else begin
            channel_out      <= main_q[`CM_CHAN_LSB+2:`CM_CHAN_LSB];
            hold_out         <= (state_q == ST_CONV);
            dac_code_out     <= sar_q;
            power_out        <= main_q[`CM_POWER_BIT];
            pin_analog_out   <= map_w;
            // external references per map code
            vref_pos_ext_out <= (cfg_q[3:0] == 4'h1) || (cfg_q[3:0] == 4'h3)
                                || (cfg_q[3:0] == 4'h5) || (cfg_q[3] && cfg_q[3:0] != 4'h9
                                && cfg_q[3:0] != 4'hE);
            vref_neg_ext_out <= (cfg_q[3:0] == 4'h8) || (cfg_q[3:0] == 4'hB)
                                || (cfg_q[3:0] == 4'hC) || (cfg_q[3:0] == 4'hD)
                                || (cfg_q[3:0] == 4'hF);
            irq_out          <= (flag_q || conv_done) && irq_en_q;
        end
    end
endmodule // sar_adc_control

/* File: hdl/sar_adc_defines.vh */
// constants for the successive-approximation converter control block
`ifndef SAR_ADC_DEFINES_VH
`define SAR_ADC_DEFINES_VH
// register byte offsets on the apb bus
`define OFS_CONTROL_MAIN   12'h000
`define OFS_CONFIG_FORMAT  12'h004
`define OFS_RESULT_HIGH    12'h008
`define OFS_RESULT_LOW     12'h00C
`define OFS_IRQ_CTRL       12'h010
// main control register fields
`define CM_POWER_BIT       0
`define CM_BUSY_BIT        2
`define CM_CHAN_LSB        3
`define CM_CLKLO_LSB       6
// configuration register fields
`define CF_MAP_LSB         0
`define CF_CLKHI_BIT       6
`define CF_JUSTIFY_BIT     7
// interrupt control register fields
`define IC_FLAG_BIT        0
`define IC_ENABLE_BIT      1
// reset values
`define RST_CONTROL_MAIN   8'h00
`define RST_CONFIG_FORMAT  8'h00
// conversion timing in bit periods
`define CONV_PERIODS       4'hC
`define WAIT_PERIODS       4'h2
`endif

/* File: hdl/sar_adc_tad_divider.v */
// conversion clock enable generator: oscillator divide or internal rc tick
`timescale 1ns/1ns
module sar_adc_tad_divider #(
    parameter RC_DIV = 100                  // system cycles per rc bit period
) (
    input  wire       sys_clk_in,           // system clock
    input  wire       rst_n_in,             // synchronous reset, active low
    input  wire       run_in,               // divider runs while high
    input  wire [2:0] clk_sel_in,           // high bit plus two low bits
    output reg        tad_tick_out          // one-cycle bit period enable
);
    reg  [7:0] div_q;                       // oscillator divide counter
    reg  [7:0] last_w;                      // terminal count for selection
    // pick terminal count per selection code
    always @* begin
        case (clk_sel_in)
            3'h0:    last_w = 8'h01;        // osc/2
            3'h1:    last_w = 8'h07;        // osc/8
            3'h2:    last_w = 8'h1F;        // osc/32
            3'h4:    last_w = 8'h03;        // osc/4
            3'h5:    last_w = 8'h0F;        // osc/16
            3'h6:    last_w = 8'h3F;        // osc/64
            default: last_w = RC_DIV[7:0] - 8'h01; // internal rc clock
        endcase
    end
    // count and emit one tick per period
    always @(posedge sys_clk_in) begin
        if (!rst_n_in || !run_in) begin
            div_q        <= 8'h00;
            tad_tick_out <= 1'b0;
        end else if (div_q >= last_w) begin
            div_q        <= 8'h00;
            tad_tick_out <= 1'b1;
        end else begin
            div_q        <= div_q + 8'h01;
            tad_tick_out <= 1'b0;
        end
    end
endmodule // sar_adc_tad_divider

/* File: tb/sar_adc_control_monitor.sv */
// assertion checker for the converter control block
`timescale 1ns/1ns
module sar_adc_control_monitor (
    input wire        sys_clk_in,       // clock
    input wire        rst_n_in,         // reset, active low
    input wire        psel_in,          // apb select
    input wire        penable_in,       // apb enable
    input wire        pwrite_in,        // apb write
    input wire [11:0] paddr_in,         // apb address
    input wire [31:0] pwdata_in,        // apb write data
    input wire [31:0] prdata_out,       // apb read data
    input wire        pready_out,       // apb ready
    input wire        pslverr_out,      // apb error
    input wire [2:0]  channel_out,      // selected channel
    input wire        hold_out,         // hold cap disconnected
    input wire        power_out,        // analog power
    input wire [7:0]  pin_analog_out,   // pin map
    input wire        vref_pos_ext_out, // external high ref
    input wire        vref_neg_ext_out  // external low ref
);
    // write strobes seen at the completing access edge
    wire wr      = psel_in && penable_in && pwrite_in && pready_out;
    wire wr_main = wr && paddr_in == 12'h000;
    wire wr_cfg  = wr && paddr_in == 12'h004;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    AST_RST_STATE: assert property (disable iff (1'b0) !rst_n_in |=>
        pin_analog_out == 8'hFF && !power_out && !hold_out) else $error("reset state wrong");
    AST_READY: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no ready in access cycle");
    AST_UNMAPPED: assert property (psel_in && penable_in && pready_out &&
        paddr_in > 12'h010 |-> pslverr_out && prdata_out == 32'h0) else $error("unmapped access");
    // register lands at the access edge, the output one edge later
    AST_CHAN: assert property (wr_main |=> ##1 channel_out == $past(pwdata_in[5:3], 2))
        else $error("channel not routed");
    AST_POWER: assert property (wr_main |=> ##1 power_out == $past(pwdata_in[0], 2))
        else $error("power bit not followed");
    AST_START_PWR: assert property ($rose(hold_out) |-> $past(power_out))
        else $error("start while unpowered");
    AST_MAP_DIG: assert property (wr_cfg && pwdata_in[3:1] == 3'b011 |=> ##1
        pin_analog_out == 8'h00 && !vref_pos_ext_out) else $error("digital map wrong");
    AST_MAP_VREF: assert property (wr_cfg && pwdata_in[3:0] == 4'h8 |=> ##1
        vref_pos_ext_out && vref_neg_ext_out) else $error("reference select wrong");
    AST_HOLD_MIN: assert property ($rose(hold_out) |-> hold_out [*8])
        else $error("hold released early");
    AST_HOLD_CHAN: assert property (hold_out && $past(hold_out) |-> $stable(channel_out))
        else $error("channel moved while held");
endmodule // sar_adc_control_monitor
bind sar_adc_control sar_adc_control_monitor i_sar_adc_control_monitor (.*);

/* File: tb/sar_adc_analog_model.sv */
// sample-and-hold and comparator standing at the analog pins
`timescale 1ns/1ns
module sar_adc_analog_model (
    input  wire       hold_in,  // high: cap disconnected from pin
    input  wire [2:0] chan_in,  // selected analog input
    input  wire [9:0] dac_in,   // trial code
    output wire       comp_out  // held sample at or above trial
);
    reg [9:0] held_q;           // level kept on the hold cap
    // each input carries its own fixed level
    wire [9:0] pin_level = 10'h3FF - chan_in * 7'd83;
    // sample frozen when the cap is disconnected
    always @(posedge hold_in) held_q <= pin_level;
    // comparison feeding the successive approximation
    assign comp_out = held_q >= dac_in;
endmodule // sar_adc_analog_model

/* File: tb/tb_top.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ns
`include "sar_adc_defines.vh"
module tb_top;
    localparam RCD = 4;  // shortened rc bit period
    // pin map per code, code 0 lowest, with reference masks
    localparam [127:0] PINS = {8'h01, 8'h01, 8'h03, 8'h13, 8'h33, 8'h37, 8'h3F, 8'hF3,
                               8'h00, 8'h00, 8'h03, 8'h0B, 8'h17, 8'h1F, 8'hF7, 8'hFF};
    localparam [15:0] VP = 16'hBD2A;  // codes with external high ref
    localparam [15:0] VN = 16'hB900;  // codes with external low ref
    localparam [23:0] CODES = {3'b111, 3'b011, 3'b110, 3'b101, 3'b100, 3'b010, 3'b001, 3'b000};
    reg        sys_clk_in = 1'b0;  // clock
    reg        rst_n_in   = 1'b0;  // reset
    reg        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, sleep_in = 1'b0;
    reg [11:0] paddr_in   = 12'h000;  // address
    reg [31:0] pwdata_in  = 32'h0;    // write data
    reg [31:0] rd;                    // last read data
    reg        err_bit;               // last error response
    reg [7:0]  m;                     // pin compare mask
    reg [9:0]  lvl;                   // expected sample
    reg [2:0]  cs;                    // clock code
    wire [31:0] prdata_out;
    wire        pready_out, pslverr_out, comp_in, hold_out, power_out, irq_out;
    wire        vref_pos_ext_out, vref_neg_ext_out;
    wire [2:0]  channel_out;
    wire [9:0]  dac_code_out;
    wire [7:0]  pin_analog_out;
    integer     errors = 0, n_tests = 0, i, k, n, dv;
    sar_adc_control #(.RC_DIV(RCD)) i_sar_adc_control (.*);
    sar_adc_analog_model i_sar_adc_analog_model (.hold_in(hold_out), .chan_in(channel_out),
                                                 .dac_in(dac_code_out), .comp_out(comp_in));
    // 25 mhz clock
    always #20 sys_clk_in = ~sys_clk_in;
    // counts, verdict, end of run
    task complete_run;
        begin
            $display("checks %0d errors %0d", n_tests, errors);
            if (errors == 0 && n_tests > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    // compare one value
    task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("ERROR %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    // one apb transfer, held until ready is sampled
    task apb(input w, input [11:0] a, input [31:0] d);
        integer t;
        begin
            @(posedge sys_clk_in);
            psel_in <= 1'b1;
            pwrite_in <= w;
            paddr_in <= a;
            pwdata_in <= d;
            @(posedge sys_clk_in);
            penable_in <= 1'b1;
            t = 0;
            do begin
                @(posedge sys_clk_in);
                t = t + 1;
            end while (pready_out !== 1'b1 && t < 20);
            rd = prdata_out;
            err_bit = pslverr_out;
            psel_in <= 1'b0;
            penable_in <= 1'b0;
            if (t >= 20) begin
                errors = errors + 1;
                complete_run;
            end
        end
    endtask
    // bounded wait for hold level, cycles left in n
    task wait_hold(input v, input integer lim);
        begin
            n = 0;
            while (hold_out !== v && n < lim) begin
                @(posedge sys_clk_in);
                n = n + 1;
            end
            if (n >= lim) begin
                errors = errors + 1;
                complete_run;
            end
        end
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        chk("pins", 8'hFF, pin_analog_out);
        apb(0, `OFS_CONTROL_MAIN, 0);
        chk("main", 0, rd);
        // pin map rows, unimplemented bits written as ones
        for (i = 0; i < 16; i = i + 1) begin
            apb(1, `OFS_CONFIG_FORMAT, 32'hB0 | i);
            apb(0, `OFS_CONFIG_FORMAT, 0);
            chk("cfg", 32'h80 | i, rd);
            m = 8'hFF & ~{4'h0, VP[i], VN[i], 2'b00};
            chk("pins", PINS[i*8 +: 8] & m, pin_analog_out & m);
            chk("vref", {VP[i], VN[i]}, {vref_pos_ext_out, vref_neg_ext_out});
        end
        // write with busy and power clear, no start, bit 1 reads zero
        apb(1, `OFS_CONTROL_MAIN, 32'hFA);
        apb(0, `OFS_CONTROL_MAIN, 0);
        chk("main", 32'hF8, rd);
        chk("idle", {3'd7, 1'b0, 1'b0}, {channel_out, power_out, hold_out});
        apb(1, `OFS_IRQ_CTRL, 32'h2);
        // one conversion per clock code and channel, all channels implemented
        // map, channel, clock and power first, start in a later write
        // the model pins are pure inputs, no output driver to disturb them
        for (k = 0; k < 8; k = k + 1) begin
            cs = CODES[k*3 +: 3];
            dv = k > 5 ? RCD : (k < 3 ? 2 : 4) << (2 * (k % 3));
            lvl = 10'h3FF - k * 83;
            sleep_in <= (cs[1:0] == 2'b11);
            apb(1, `OFS_CONFIG_FORMAT, {24'h0, k[0], cs[2], 6'h00});
            apb(1, `OFS_CONTROL_MAIN, {24'h0, cs[1:0], k[2:0], 3'b001});
            apb(1, `OFS_CONTROL_MAIN, {24'h0, cs[1:0], k[2:0], 3'b101});
            wait_hold(1, 4);
            chk("chan", k, channel_out);
            wait_hold(0, 14 * dv);
            chk("length", 1, n > 11 * dv && n <= 13 * dv);
            apb(0, `OFS_CONTROL_MAIN, 0);
            chk("busy", {cs[1:0], k[2:0], 3'b001}, rd);
            apb(0, `OFS_RESULT_HIGH, 0);
            chk("hi", k[0] ? lvl >> 8 : lvl >> 2, rd);
            apb(0, `OFS_RESULT_LOW, 0);
            chk("lo", k[0] ? lvl[7:0] : {lvl[1:0], 6'h00}, rd);
            chk("irq", 1, irq_out);
            apb(1, `OFS_IRQ_CTRL, 32'h2);
            apb(0, `OFS_IRQ_CTRL, 0);
            chk("flag", 32'h2, rd);
            chk("irqoff", 0, irq_out);
            repeat (3 * dv) @(posedge sys_clk_in);
        end
        // divided clock stalls asleep, then abort keeps result
        sleep_in <= 1'b1;
        apb(1, `OFS_CONFIG_FORMAT, 32'h80);
        apb(1, `OFS_CONTROL_MAIN, 32'h01);
        apb(1, `OFS_CONTROL_MAIN, 32'h05);
        wait_hold(1, 4);
        repeat (60) @(posedge sys_clk_in);
        chk("stall", 1, hold_out);
        apb(1, `OFS_CONTROL_MAIN, 32'h01);
        wait_hold(0, 8);
        apb(0, `OFS_CONTROL_MAIN, 0);
        chk("abort", 32'h01, rd);
        apb(0, `OFS_RESULT_HIGH, 0);
        chk("kept", lvl >> 8, rd);
        // reset in mid conversion
        sleep_in <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        apb(1, `OFS_CONTROL_MAIN, 32'h05);
        wait_hold(1, 4);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        chk("rsthold", 0, {hold_out, power_out});
        chk("rstpins", 8'hFF, pin_analog_out);
        apb(1, `OFS_CONFIG_FORMAT, 32'h80);
        apb(0, `OFS_RESULT_HIGH, 0);
        chk("rstres", lvl >> 8, rd);
        apb(0, 12'h014, 0);
        chk("unmap", 32'h0, rd);
        chk("unmaperr", 1, err_bit);
        complete_run;
    end
endmodule // tb_top
